/* bench/clk_ctrl_monitor.sv */
// assertion checker on the ports of the clock control unit
`timescale 1ns/1ps
`default_nettype none
module clk_ctrl_monitor
   import clk_ctrl_pkg::*;
#(
   parameter logic [13:0] TOUT_LONG_CYC = TOUT_LONG,
   parameter logic [15:0] STAB_LF_CYC   = STAB_LF
) (
   // clock, reset, inputs
   input wire logic       ref_clk,
   input wire logic       arst_n,
   input wire logic       clk_en,
   input wire fuse_s      fuses_in,
   input wire logic       rst_src_n,
   input wire logic       wake_pin,
   input wire logic       wdt_osc,
   input wire logic       sel_osc,
   input wire logic       asy_osc,
   input wire logic [1:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       wr,
   input wire logic       rd,
   // outputs
   input wire logic [7:0] rdata,
   input wire logic [5:0] src_sel,
   input wire logic       int_rst_n,
   input wire logic       sys_ce,
   input wire domain_s    dom_ce
);
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (!arst_n);

   AST_SRC_ONEHOT: assert property ($onehot0(src_sel))
      else $error("source select not one-hot");
   AST_RESV_STUCK: assert property (src_sel == 6'h00 |-> !int_rst_n && !sys_ce)
      else $error("left reset without a source");
   // release is decided from the synced source, seen three samples back
   AST_REL_SRC_HIGH: assert property ($rose(int_rst_n) |-> $past(rst_src_n, 3))
      else $error("released while a source held reset");
   AST_SRC_RESTART: assert property (!rst_src_n |-> ##[0:4] !int_rst_n)
      else $error("reset source did not reach internal reset");
   AST_FLASH_WITH_CPU: assert property (dom_ce.flash == dom_ce.cpu)
      else $error("flash tick apart from cpu tick");
   AST_DOM_ON_TICK: assert property (dom_ce.cpu || dom_ce.io || dom_ce.adc |-> sys_ce)
      else $error("domain tick without system tick");
   AST_DIV8_SPACING: assert property (!fuses_in.divide_by_eight_fuse && sys_ce |=> !sys_ce [*7])
      else $error("divided tick too close");
   AST_HALT_CPU: assert property (wr && addr == CTRL_OFS && rst_src_n && wdata[CTRL_HALT_CPU]
      |-> ##3 (!dom_ce.cpu) [*4])
      else $error("cpu ticks while halted");
   AST_RDATA_IDLE: assert property (!$past(rd) |-> rdata == 8'h00)
      else $error("read data outside its cycle");
   AST_ASY_TICK: assert property ($rose(asy_osc) && int_rst_n
      |-> ##[1:5] (dom_ce.async_timer_clock_domain || !int_rst_n))
      else $error("async timer tick missing");
endmodule : clk_ctrl_monitor

bind clk_ctrl clk_ctrl_monitor #(.TOUT_LONG_CYC(TOUT_LONG_CYC), .STAB_LF_CYC(STAB_LF_CYC)) mon (
   .ref_clk, .arst_n, .clk_en, .fuses_in, .rst_src_n, .wake_pin, .wdt_osc, .sel_osc,
   .asy_osc, .addr, .wdata, .wr, .rd, .rdata, .src_sel, .int_rst_n, .sys_ce, .dom_ce);
`default_nettype wire

/* bench/osc_model.sv */
// oscillator sources standing outside the clock control unit
`timescale 1ns/1ps
`default_nettype none
module osc_model (
   // reference that paces the waveforms
   input  wire logic ref_clk,
   // oscillator waveforms
   output var logic  wdt_osc,
   output var logic  sel_osc,
   output var logic  asy_osc
);
   int k = 0;

   // oscillators run free; each phase spans whole cycles so the two-flop sync sees it
   always @(posedge ref_clk) begin
      k <= k + 1;
      wdt_osc <= k[1];
      sel_osc <= k[1];
      asy_osc <= (k % 6) < 3;
   end
endmodule : osc_model
`default_nettype wire

/* bench/tb_top.sv */
// self-checking bench: source decode, start-up timing, gating, register port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import clk_ctrl_pkg::*;
   logic        ref_clk, arst_n, rst_src_n, wake_pin, wr, rd;
   logic        wdt_osc, sel_osc, asy_osc, int_rst_n, sys_ce;
   logic [1:0]  addr;
   logic [7:0]  wdata, rdata;
   logic [5:0]  src_sel;
   fuse_s       fuses;
   domain_s     dom_ce;
   int          n_errors, n_compared;
   logic [31:0] seed;

   // long counts shortened so the run stays brief
   clk_ctrl #(.TOUT_LONG_CYC(14'h0010), .STAB_LF_CYC(16'h0020)) dut (
      .ref_clk, .arst_n, .clk_en(1'b1), .fuses_in(fuses), .rst_src_n, .wake_pin,
      .wdt_osc, .sel_osc, .asy_osc, .addr, .wdata, .wr, .rd, .rdata,
      .src_sel, .int_rst_n, .sys_ce, .dom_ce);
   osc_model osc (.ref_clk, .wdt_osc, .sel_osc, .asy_osc);

   // 125 mhz reference
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs

   function automatic logic [5:0] exp_sel(input logic [3:0] c);
      if (c[3]) return 6'h01;
      if (c[2:1] == 2'h3) return 6'h02;
      if (c[2:1] == 2'h2) return 6'h04;
      return c[1:0] == 2'h3 ? 6'h08 : c[1:0] == 2'h2 ? 6'h10 : c[1:0] == 2'h0 ? 6'h20 : 6'h00;
   endfunction : exp_sel

   // reference cycles to release: both oscillators have a four-cycle period
   function automatic int exp_len(input logic [3:0] c, input logic [1:0] s);
      int t;
      int b;
      int k;
      k = {c[0], s};
      t = s == 2'h0 ? 0 : s == 2'h1 ? 512 : 16;
      b = c[2:1] == 2'h2 ? 32 : 6;
      if (c[3] || c[2:1] == 2'h3) begin
         t = k % 3 == 0 ? 512 : k % 3 == 1 ? 16 : 0;
         b = k < 2 ? 258 : k < 5 ? 1024 : 16384;
      end
      return 4 * (t + b);
   endfunction : exp_len

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : tally_and_finish

   task automatic reset_to(input logic [3:0] c, input logic [1:0] s, input logic d);
      @(posedge ref_clk);
      arst_n <= 1'b0;
      fuses <= '{c, s, d};
      repeat (5) @(posedge ref_clk);
      arst_n <= 1'b1;
   endtask : reset_to

   // bounded wait for the internal reset to lift
   task automatic wait_rel(output int n);
      n = 0;
      while (int_rst_n !== 1'b1 && n < 6000) begin
         @(negedge ref_clk);
         n++;
      end
      if (n == 6000) begin
         check("release_wait", 0, 1);
         tally_and_finish();
      end
   endtask : wait_rel

   task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge ref_clk);
      wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [1:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge ref_clk);
      rd <= 1'b0;
      @(negedge ref_clk);
      check("rdata", rdata, e);
   endtask : rd_reg

   task automatic cnt_dom(output int c, output int i, output int a, output int y);
      {c, i, a, y} = '0;
      repeat (32) begin
         @(negedge ref_clk);
         c += dom_ce.cpu;
         i += dom_ce.io;
         a += dom_ce.adc;
         y += dom_ce.async_timer_clock_domain;
      end
   endtask : cnt_dom

   // main sequence
   initial begin
      int         n, c, i, a, y, e;
      logic [3:0] s4;
      logic [1:0] ad;
      logic       d, hi;
      logic [2:0] ctl;
      logic [6:0] cfg [6] = '{7'h14, 7'h01, 7'h1a, 7'h21, 7'h40, 7'h35};
      // reset asserted, reset source released, all strobes idle
      {arst_n, rst_src_n, wake_pin, wr, rd, addr, wdata} = 15'h2000;
      fuses = '{FUSE_SRC_RST, FUSE_SUT_RST, FUSE_DIV8_RST};
      {n_errors, n_compared} = '0;
      seed = 32'hdf67;
      for (int k = 0; k < 16; k++) begin
         reset_to(k[3:0], 2'h2, 1'b1);
         repeat (6) @(negedge ref_clk);
         check("src_sel", src_sel, exp_sel(k[3:0]));
      end
      $display("test decode done");
      foreach (cfg[j]) begin
         {s4, ad, d} = cfg[j];
         ctl = 3'h0;
         e = d ? 32 : 4;
         reset_to(s4, ad, d);
         wait_rel(n);
         check("release", n >= exp_len(s4, ad) - 8 && n <= exp_len(s4, ad) + 24, 1);
         repeat (4) begin
            seed = xs(seed);
            wr_reg(seed[1:0], {5'h0, seed[10:8]});
            if (seed[1:0] == CTRL_OFS) ctl = seed[10:8];
            rd_reg(seed[3:2], seed[3:2] == CTRL_OFS ? {5'h0, ctl}
               : seed[3:2] == STAT_OFS ? {s4, ~d, 1'b0, 2'h3} : 8'h00);
            cnt_dom(c, i, a, y);
            check("cpu", c, ctl[0] ? 0 : e);
            check("io", i, ctl[1] ? 0 : e);
            check("adc", a, ctl[2] ? 0 : e);
         end
      end
      $display("test start-up and gating done");
      reset_to(4'h0, 2'h2, 1'b1);
      wait_rel(n);
      wr_reg(CTRL_OFS, 8'h08);
      rd_reg(STAT_OFS, 8'h02);
      cnt_dom(c, i, a, y);
      check("sleep_cpu", c, 0);
      check("sleep_async", y >= 4, 1);
      @(posedge ref_clk);
      wake_pin <= 1'b1;
      hi = 1'b1;
      n = 0;
      while (dom_ce.cpu !== 1'b1 && n < 200) begin
         @(negedge ref_clk);
         hi &= int_rst_n;
         n++;
      end
      wake_pin <= 1'b0;
      check("wake_len", n >= 20 && n <= 40, 1);
      check("wake_rst", hi, 1);
      rd_reg(CTRL_OFS, 8'h00);
      $display("test sleep done");
      // a reset source in mid time-out must start the whole wait again
      reset_to(4'h0, 2'h2, 1'b1);
      repeat (40) @(posedge ref_clk);
      rst_src_n <= 1'b0;
      repeat (3) @(posedge ref_clk);
      rst_src_n <= 1'b1;
      wait_rel(n);
      check("restart", n >= 80 && n <= 112, 1);
      wr_reg(CTRL_OFS, 8'h03);
      rst_src_n <= 1'b0;
      repeat (3) @(posedge ref_clk);
      rst_src_n <= 1'b1;
      @(negedge ref_clk);
      check("int_rst_n", int_rst_n, 0);
      rd_reg(CTRL_OFS, 8'h00);
      $display("test reset source done");
      tally_and_finish();
   end
endmodule : tb_top
`default_nettype wire

/* logic/clk_ctrl.sv */
// clock source selection, domain gating and start-up reset sequencing
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module clk_ctrl
   import clk_ctrl_pkg::*;
#(
   parameter logic [13:0] TOUT_LONG_CYC = TOUT_LONG,
   parameter logic [15:0] STAB_LF_CYC   = STAB_LF
) (
   // clock, reset and freeze
   input  wire logic       ref_clk,
   input  wire logic       arst_n,
   input  wire logic       clk_en,
   // fuse pins, static configuration
   input  wire fuse_s      fuses_in,
   // other reset sources and sleep wake pin, asynchronous
   input  wire logic       rst_src_n,
   input  wire logic       wake_pin,
   // oscillator outputs from other clocks
   input  wire logic       wdt_osc,
   input  wire logic       sel_osc,
   input  wire logic       asy_osc,
   // register port
   input  wire logic [1:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic      [7:0] rdata,
   // clock selection, internal reset and domain enables
   output logic      [5:0] src_sel,
   output logic            int_rst_n,
   output logic            sys_ce,
   output domain_s         dom_ce
);

   // fuse image held in the sync stages while reset is asserted
   // matches the delivered state so the first edges already see a legal source
   // and the time-out never counts against a half-loaded field
   localparam fuse_s FUSE_RST = '{
      clock_source_fuses:   FUSE_SRC_RST,
      startup_delay_fuses:  FUSE_SUT_RST,
      divide_by_eight_fuse: FUSE_DIV8_RST
   };

   // whole state at reset: internal reset low, no source selected, no ticks
   // synchronisers clear to zero, so the reset source reads as asserted
   // for two edges and the sequencer cannot start before the fuses settle
   localparam state_s STATE_RST = '{
      rst_sync:         3'h0,
      wake_sync:        3'h0,
      wdt_sync:         3'h0,
      osc_sync:         3'h0,
      asy_sync:         3'h0,
      fuse_m:           FUSE_RST,
      fuse_q:           FUSE_RST,
      phase:            ST_TIMEOUT,
      from_reset:       1'b1,
      power_up_timeout: 14'h0000,
      stab_cnt:         16'h0000,
      div_cnt:          3'h0,
      ctrl:             4'h0,
      rdata:            8'h00,
      src_sel:          6'h00,
      irst_n:           1'b0,
      sys_ce:           1'b0,
      dom_ce:           5'h00
   };

   // s is the registered state, n the value it takes at the next enabled edge
   // keeping one struct makes the freeze by clock enable cover every bit
   state_s s;
   state_s n;

   // source fuse field to clock source
   // top bit set means low power crystal whatever the lower bits hold
   // the reserved code falls to the default branch and selects nothing
   function automatic src_e src_decode(input logic [3:0] code);
      if (code[3])
         return SRC_LP_XTAL;
      unique case (code[2:0])
         3'h7, 3'h6: return SRC_FS_XTAL;
         3'h5, 3'h4: return SRC_LF_XTAL;
         3'h3:       return SRC_RC128;
         3'h2:       return SRC_RC_CAL;
         3'h0:       return SRC_EXT;
         default:    return SRC_NONE;
      endcase
   endfunction : src_decode

   // crystal sources index the delay by source bit 0 and start-up bits
   function automatic logic [2:0] xtal_idx(input fuse_s f);
      return {f.clock_source_fuses[0], f.startup_delay_fuses};
   endfunction : xtal_idx

   // low power and full swing crystals share one start-up table
   // the low frequency crystal is kept apart: its count is much longer
   function automatic logic is_xtal(input src_e src);
      return (src == SRC_LP_XTAL) || (src == SRC_FS_XTAL);
   endfunction : is_xtal

   // power-up time-out length in watchdog cycles
   // a zero length is only safe when a brown-out monitor guards the supply
   // non-crystal sources pick the length from the start-up field alone
   function automatic logic [13:0] tout_len(input src_e src, input fuse_s f);
      logic [2:0] i;
      i = xtal_idx(f);
      if (is_xtal(src)) begin
         unique case (i)
            3'h2, 3'h5:       return TOUT_NONE;
            3'h0, 3'h3, 3'h6: return TOUT_SHORT;
            default:          return TOUT_LONG_CYC;
         endcase
      end
      unique case (f.startup_delay_fuses)
         2'h0:    return TOUT_NONE;
         2'h1:    return TOUT_SHORT;
         default: return TOUT_LONG_CYC;
      endcase
   endfunction : tout_len

   // oscillator stability length in selected oscillator cycles
   // resonators settle quicker than crystals, hence the shorter counts
   // external and rc sources only need the minimum count
   function automatic logic [15:0] stab_len(input src_e src, input fuse_s f);
      logic [2:0] i;
      i = xtal_idx(f);
      if (src == SRC_LF_XTAL)
         return STAB_LF_CYC;
      if (!is_xtal(src))
         return STAB_EXT;
      unique case (i)
         3'h0, 3'h1:       return STAB_258;
         3'h2, 3'h3, 3'h4: return STAB_1K;
         default:          return STAB_16K;
      endcase
   endfunction : stab_len

   // whole next-state computation
   always_comb begin
      logic        wdt_tick;
      logic        osc_tick;
      logic        asy_tick;
      logic        sys_tick;
      logic        run;
      src_e        src;
      logic [13:0] tlen;
      logic [15:0] slen;
      wdt_tick = 1'b0;
      osc_tick = 1'b0;
      asy_tick = 1'b0;
      sys_tick = 1'b0;
      run      = 1'b0;
      src      = SRC_NONE;
      tlen     = TOUT_NONE;
      slen     = STAB_EXT;
      n        = s;

      // two-stage synchronisers, third stage only for edge detection
      // oscillator phases shorter than one reference cycle can be lost here,
      // so the reference must run well above every counted oscillator
      n.rst_sync  = {s.rst_sync[1:0], rst_src_n};
      n.wake_sync = {s.wake_sync[1:0], wake_pin};
      n.wdt_sync  = {s.wdt_sync[1:0], wdt_osc};
      n.osc_sync  = {s.osc_sync[1:0], sel_osc};
      n.asy_sync  = {s.asy_sync[1:0], asy_osc};
      n.fuse_m    = fuses_in;
      n.fuse_q    = s.fuse_m;
      wdt_tick    = s.wdt_sync[1] & ~s.wdt_sync[2];
      osc_tick    = s.osc_sync[1] & ~s.osc_sync[2];
      asy_tick    = s.asy_sync[1] & ~s.asy_sync[2];

      src  = src_decode(s.fuse_q.clock_source_fuses);
      tlen = tout_len(src, s.fuse_q);
      slen = stab_len(src, s.fuse_q);

      // register port: read data only in the cycle after the strobe
      // idle read data is zero so a bus or-tree needs no extra gating
      n.rdata = 8'h00;
      if (rd) begin
         unique case (addr)
            CTRL_OFS: n.rdata = {4'h0, s.ctrl};
            STAT_OFS: n.rdata = {s.fuse_q.clock_source_fuses,
                                 ~s.fuse_q.divide_by_eight_fuse,
                                 src == SRC_NONE, s.phase};
            default:  n.rdata = 8'h00;
         endcase
      end
      if (wr && addr == CTRL_OFS)
         n.ctrl = wdata[3:0];

      // start-up and sleep sequencing
      // timeout counts watchdog ticks, stable counts selected oscillator ticks;
      // wake from sleep skips the timeout because the supply is already up;
      // a reserved source code parks the sequencer in timeout for good
      unique case (s.phase)
         ST_TIMEOUT: begin
            if (src == SRC_NONE) begin
               n.power_up_timeout = 14'h0000;
            end else if (tlen == TOUT_NONE) begin
               n.phase = ST_STABLE;
            end else if (wdt_tick) begin
               if (s.power_up_timeout == tlen - 14'h0001) begin
                  n.phase = ST_STABLE;
                  n.power_up_timeout = 14'h0000;
               end else begin
                  n.power_up_timeout = s.power_up_timeout + 14'h0001;
               end
            end
         end
         ST_STABLE: begin
            if (src != SRC_NONE && osc_tick) begin
               if (s.stab_cnt == slen - 16'h0001) begin
                  n.phase      = ST_RUN;
                  n.stab_cnt   = 16'h0000;
                  n.from_reset = 1'b0;
               end else begin
                  n.stab_cnt = s.stab_cnt + 16'h0001;
               end
            end
         end
         ST_RUN: begin
            if (s.ctrl[CTRL_SLEEP])
               n.phase = ST_SLEEP;
         end
         ST_SLEEP: begin
            // wake pin is sampled on ref_clk, not on any gated domain
            if (s.wake_sync[1]) begin
               n.phase = ST_STABLE;
               n.ctrl[CTRL_SLEEP] = 1'b0;
            end
         end
      endcase

      // a reasserted reset source overrides the phase, counters and control register set above
      if (!s.rst_sync[1]) begin
         n.phase            = ST_TIMEOUT;
         n.from_reset       = 1'b1;
         n.power_up_timeout = 14'h0000;
         n.stab_cnt         = 16'h0000;
         n.ctrl             = 4'h0;
      end

      // prescaler keeps counting so the divided phase never jumps
      // trade-off: the first divided tick after release may come early
      n.div_cnt = s.div_cnt + 3'h1;
      sys_tick  = s.fuse_q.divide_by_eight_fuse
                  || (s.div_cnt == DIV_LAST);
      run       = (s.phase == ST_RUN);

      // outputs, all registered
      // internal reset follows the next phase so it lifts on the same edge
      // that enters run; wake from sleep keeps it high throughout
      n.irst_n = !(n.phase == ST_TIMEOUT
                   || (n.phase == ST_STABLE && n.from_reset));
      n.src_sel = 6'h00;
      if (src != SRC_NONE)
         n.src_sel[src] = 1'b1;
      n.sys_ce = sys_tick && run;
      n.dom_ce.cpu   = n.sys_ce && !s.ctrl[CTRL_HALT_CPU];
      n.dom_ce.flash = n.sys_ce && !s.ctrl[CTRL_HALT_CPU];
      n.dom_ce.io    = n.sys_ce && !s.ctrl[CTRL_HALT_IO];
      n.dom_ce.adc   = n.sys_ce && !s.ctrl[CTRL_HALT_ADC];
      // timer domain ignores sleep so real time keeps counting
      n.dom_ce.async_timer_clock_domain = asy_tick && s.irst_n;
   end

   // single state register; clock enable freezes everything
   // domains get enable pulses, not gated clocks, to keep one clock tree
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         s <= STATE_RST;
      end else if (clk_en) begin
         s <= n;
      end
   end

   // every output is a plain copy of a state bit, so no logic sits after the flops
   assign rdata     = s.rdata;
   assign src_sel   = s.src_sel;
   assign int_rst_n = s.irst_n;
   assign sys_ce    = s.sys_ce;
   assign dom_ce    = s.dom_ce;

endmodule : clk_ctrl
`default_nettype wire

/* logic/clk_ctrl_pkg.sv */
// shared constants and types for the clock source and start-up reset unit
package clk_ctrl_pkg;
   // register offsets on the plain register port
   localparam logic [1:0] CTRL_OFS = 2'h0;
   localparam logic [1:0] STAT_OFS = 2'h1;
   // control register bit positions
   localparam int CTRL_HALT_CPU = 0;
   localparam int CTRL_HALT_IO  = 1;
   localparam int CTRL_HALT_ADC = 2;
   localparam int CTRL_SLEEP    = 3;
   // delivered fuse state: calibrated rc, start-up 10, divide programmed
   localparam logic [3:0] FUSE_SRC_RST  = 4'h2;
   localparam logic [1:0] FUSE_SUT_RST  = 2'h2;
   localparam logic       FUSE_DIV8_RST = 1'b0;
   // power-up time-out lengths in watchdog oscillator cycles
   localparam int         TOUT_W     = 14;
   localparam logic [13:0] TOUT_NONE  = 14'h0000;
   localparam logic [13:0] TOUT_SHORT = 14'h0200;
   localparam logic [13:0] TOUT_LONG  = 14'h2000;
   // oscillator stability counts in selected oscillator cycles
   localparam int          STAB_W    = 16;
   localparam logic [15:0] STAB_EXT  = 16'h0006;
   localparam logic [15:0] STAB_258  = 16'h0102;
   localparam logic [15:0] STAB_1K   = 16'h0400;
   localparam logic [15:0] STAB_16K  = 16'h4000;
   localparam logic [15:0] STAB_LF   = 16'h8000;
   // system clock prescaler terminal count for divide by eight
   localparam logic [2:0]  DIV_LAST  = 3'h7;

   typedef struct packed {
      logic [3:0] clock_source_fuses;
      logic [1:0] startup_delay_fuses;
      logic       divide_by_eight_fuse; // 0 means programmed
   } fuse_s;

   typedef struct packed {
      logic cpu;
      logic io;
      logic flash;
      logic async_timer_clock_domain;
      logic adc;
   } domain_s;

   typedef enum logic [1:0] {
      ST_TIMEOUT = 2'b00,
      ST_STABLE  = 2'b01,
      ST_RUN     = 2'b11,
      ST_SLEEP   = 2'b10
   } phase_e;

   typedef enum logic [2:0] {
      SRC_LP_XTAL = 3'h0,
      SRC_FS_XTAL = 3'h1,
      SRC_LF_XTAL = 3'h2,
      SRC_RC128   = 3'h3,
      SRC_RC_CAL  = 3'h4,
      SRC_EXT     = 3'h5,
      SRC_NONE    = 3'h6
   } src_e;

   typedef logic [2:0] sync_t;

   typedef struct packed {
      sync_t       rst_sync;
      sync_t       wake_sync;
      sync_t       wdt_sync;
      sync_t       osc_sync;
      sync_t       asy_sync;
      fuse_s       fuse_m;
      fuse_s       fuse_q;
      phase_e      phase;
      logic        from_reset;
      logic [13:0] power_up_timeout;
      logic [15:0] stab_cnt;
      logic [2:0]  div_cnt;
      logic [3:0]  ctrl;
      logic [7:0]  rdata;
      logic [5:0]  src_sel;
      logic        irst_n;
      logic        sys_ce;
      domain_s     dom_ce;
   } state_s;
endpackage : clk_ctrl_pkg
